// [pkg/fp_ctrl_pkg.sv]
package fp_ctrl_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_GAIN = 4'h8;
  localparam logic [3:0] OFS_LEDS = 4'hc;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTL_SRC_LSB = 0;
  localparam int CTL_TBC_BIT = 4;
  localparam int CTL_STD_BIT = 5;
  localparam int STS_EDIT_BIT = 0;
  localparam int STS_GROUP_LSB = 1;
  localparam int STS_DIRTY_BIT = 3;
  localparam int STS_SAVE_BIT = 4;
  localparam int STS_INP_BIT = 5;
  localparam int STS_REF_BIT = 6;
  localparam logic [7:0] GAIN_UNITY = 8'h64;
  localparam logic [7:0] GAIN_MIN = 8'h32;
  localparam logic [7:0] GAIN_MAX = 8'h96;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic TBC_RESET = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_HZ = 10000000;
  localparam longint BLINK_SEC = 15;
  localparam longint BLINK_CYCLES = BLINK_SEC * CLK_HZ;
  localparam longint FLASH_HALF_CYCLES = CLK_HZ / 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SRC_COMPOSITE,
    SRC_LUMA_CHROMA,
    SRC_COMP_BETA,
    SRC_COMP_SMPTE,
    SRC_COLOR_BARS,
    SRC_CHECKFIELD
  } source_e;

  typedef enum logic [1:0] {
    GRP_SOURCE,
    GRP_TBC,
    GRP_GAIN
  } group_e;

  typedef struct packed {
    logic section;
    logic left;
    logic right;
  } buttons_s;

  typedef struct packed {
    logic [5:0] source_green;
    logic input_green;
    logic ref_green;
    logic tbc_green;
    logic gain_green;
    logic gain_red;
  } leds_s;

  typedef struct packed {
    logic [2:0] source;
    logic tbc_en;
    logic [7:0] gain;
  } settings_s;

endpackage

// [src/fp_ctrl.sv]
// What this block does
// - section button enters editing and steps through parameter groups, wrapping
// - right arrow advances or increases, left arrow moves back or decreases
// - changed parameter LED blinks fifteen seconds, then value is saved
// - value saved only after timeout; power loss before it discards edit
// - six sources; only chosen source LED lit green
// - input LED green on detected signal, dark for internal patterns
// - reference LED green while reference detected
// - gain LED green at unity, red otherwise
// - time base correction LED green while frame sync enabled
// - enabled sync starts output frames with reference frames
// - rate differences absorbed by at most one frame of buffering
// - internal video 4:2:2 at 27 MHz, serialized at 270 Mb/s
// - supports 525-line 60 Hz and 625-line 50 Hz standards
// - host-only parameters are neither shown nor changed from panel
// - in sync group left disables, right enables
// - in gain group both arrows return gain to unity
`timescale 1ns/10ps
module fp_ctrl #(
  parameter longint BLINK_CYCLES = fp_ctrl_pkg::BLINK_CYCLES,
  parameter longint FLASH_HALF = fp_ctrl_pkg::FLASH_HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire fp_ctrl_pkg::buttons_s buttons_i,
  input wire logic input_detect_i,
  input wire logic ref_detect_i,
  input wire logic ref_frame_start_i,
  output fp_ctrl_pkg::leds_s leds_o,
  output fp_ctrl_pkg::settings_s settings_o,
  output logic save_pulse_o,
  output logic output_frame_start_o
);

  // ****************************************
  // parameter checks
  // ****************************************
  if (BLINK_CYCLES < 2 || FLASH_HALF < 1 || FLASH_HALF >= BLINK_CYCLES) begin : g_bad_timing
    $error("fp_ctrl: bad timing parameters");
  end

  localparam int TW = $clog2(BLINK_CYCLES + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= {buttons_i, input_detect_i, ref_detect_i, ref_frame_start_i};
      sync2_r <= sync1_r;
    end
  end

  logic [5:0] prev_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_r <= 6'h00;
    end else begin
      prev_r <= sync2_r;
    end
  end

  logic sect_press;
  logic left_press;
  logic right_press;
  logic both_press;
  logic inp_det;
  logic ref_det;
  logic ref_sof;
  assign sect_press = sync2_r[5] & ~prev_r[5];
  assign left_press = sync2_r[4] & ~prev_r[4] & ~sync2_r[3];
  assign right_press = sync2_r[3] & ~prev_r[3] & ~sync2_r[4];
  assign both_press = sync2_r[4] & sync2_r[3] & ~(prev_r[4] & prev_r[3]);
  assign inp_det = sync2_r[2];
  assign ref_det = sync2_r[1];
  assign ref_sof = sync2_r[0] & ~prev_r[0];

  // ****************************************
  // bus access decode
  // ****************************************
  logic wr_ctl;
  logic wr_gain;
  logic rd_done_r;
  // readdata is registered, so every read waits one cycle for it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= avs_read_i && !rd_done_r;
    end
  end
  // writes never wait
  assign avs_waitrequest_o = avs_read_i && !rd_done_r;
  assign wr_ctl = avs_write_i && avs_address_i == fp_ctrl_pkg::OFS_CONTROL && avs_byteenable_i[0];
  assign wr_gain = avs_write_i && avs_address_i == fp_ctrl_pkg::OFS_GAIN && avs_byteenable_i[0];

  // ****************************************
  // panel navigation
  // ****************************************
  fp_ctrl_pkg::group_e group_r;
  logic editing_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      editing_r <= 1'b0;
      group_r <= fp_ctrl_pkg::GRP_SOURCE;
    end else if (sect_press) begin
      editing_r <= 1'b1;
      if (!editing_r) begin
        group_r <= fp_ctrl_pkg::GRP_SOURCE;
      end else begin
        case (group_r)
          fp_ctrl_pkg::GRP_SOURCE: group_r <= fp_ctrl_pkg::GRP_TBC;
          fp_ctrl_pkg::GRP_TBC: group_r <= fp_ctrl_pkg::GRP_GAIN;
          default: group_r <= fp_ctrl_pkg::GRP_SOURCE;
        endcase
      end
    end
  end

  function automatic logic [2:0] src_step(input logic [2:0] s, input logic up);
    logic [2:0] r;
    r = s;
    if (up) begin
      r = (s == 3'h5) ? 3'h0 : s + 3'h1;
    end else begin
      r = (s == 3'h0) ? 3'h5 : s - 3'h1;
    end
    return r;
  endfunction

  // ****************************************
  // live settings
  // ****************************************
  logic [2:0] src_r;
  logic tbc_r;
  logic [7:0] gain_r;
  logic std625_r;
  logic panel_edit;
  assign panel_edit = editing_r && (left_press || right_press || both_press);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_r <= fp_ctrl_pkg::SRC_RESET;
    end else if (editing_r && group_r == fp_ctrl_pkg::GRP_SOURCE && (left_press || right_press)) begin
      src_r <= src_step(src_r, right_press);
    end else if (wr_ctl && avs_writedata_i[2:0] <= 3'h5) begin
      src_r <= avs_writedata_i[2:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbc_r <= fp_ctrl_pkg::TBC_RESET;
    end else if (editing_r && group_r == fp_ctrl_pkg::GRP_TBC && (left_press || right_press)) begin
      tbc_r <= right_press;
    end else if (wr_ctl) begin
      tbc_r <= avs_writedata_i[fp_ctrl_pkg::CTL_TBC_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_r <= fp_ctrl_pkg::GAIN_UNITY;
    end else if (editing_r && group_r == fp_ctrl_pkg::GRP_GAIN && both_press) begin
      gain_r <= fp_ctrl_pkg::GAIN_UNITY;
    end else if (editing_r && group_r == fp_ctrl_pkg::GRP_GAIN && right_press) begin
      gain_r <= (gain_r < fp_ctrl_pkg::GAIN_MAX) ? gain_r + 8'h01 : gain_r;
    end else if (editing_r && group_r == fp_ctrl_pkg::GRP_GAIN && left_press) begin
      gain_r <= (gain_r > fp_ctrl_pkg::GAIN_MIN) ? gain_r - 8'h01 : gain_r;
    end else if (wr_gain) begin
      gain_r <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      std625_r <= 1'b0;
    end else if (wr_ctl) begin
      std625_r <= avs_writedata_i[fp_ctrl_pkg::CTL_STD_BIT];
    end
  end

  // ****************************************
  // blink and commit timer
  // ****************************************
  logic [TW-1:0] timer_r;
  logic dirty_r;
  logic save_r;
  logic timer_done;
  assign timer_done = dirty_r && timer_r == TW'(BLINK_CYCLES - 1);

  // edited group kept, so its lamp blinks even after section moves on
  fp_ctrl_pkg::group_e edit_grp_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edit_grp_r <= fp_ctrl_pkg::GRP_SOURCE;
    end else if (panel_edit) begin
      edit_grp_r <= group_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_r <= '0;
      dirty_r <= 1'b0;
    end else if (panel_edit) begin
      timer_r <= '0;
      dirty_r <= 1'b1;
    end else if (timer_done) begin
      timer_r <= '0;
      dirty_r <= 1'b0;
    end else if (dirty_r) begin
      timer_r <= timer_r + TW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      save_r <= 1'b0;
    end else begin
      // strobe only: the stored copy is taken from settings_o outside
      save_r <= timer_done && !panel_edit;
    end
  end

  logic [TW-1:0] flash_cnt_r;
  logic flash_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flash_cnt_r <= '0;
      flash_r <= 1'b1;
    end else if (!dirty_r || panel_edit) begin
      flash_cnt_r <= '0;
      flash_r <= 1'b1;
    end else if (flash_cnt_r == TW'(FLASH_HALF - 1)) begin
      flash_cnt_r <= '0;
      flash_r <= ~flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + TW'(1);
    end
  end

  // ****************************************
  // output frame alignment
  // ****************************************
  // align to reference
  // one-frame buffer handled by video path
  // 27 MHz path is outside this block
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      output_frame_start_o <= 1'b0;
    end else begin
      output_frame_start_o <= tbc_r && ref_det && ref_sof;
    end
  end

  // ****************************************
  // indicators
  // ****************************************
  logic blink_src;
  logic blink_tbc;
  logic blink_gain;
  assign blink_src = dirty_r && edit_grp_r == fp_ctrl_pkg::GRP_SOURCE && !flash_r;
  assign blink_tbc = dirty_r && edit_grp_r == fp_ctrl_pkg::GRP_TBC && !flash_r;
  assign blink_gain = dirty_r && edit_grp_r == fp_ctrl_pkg::GRP_GAIN && !flash_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      leds_o <= '0;
      settings_o <= '0;
    end else begin
      leds_o.source_green <= blink_src ? 6'h00 : 6'(6'h01 << src_r);
      leds_o.input_green <= inp_det && src_r < 3'h4;
      leds_o.ref_green <= ref_det;
      leds_o.tbc_green <= tbc_r && !blink_tbc;
      leds_o.gain_green <= gain_r == fp_ctrl_pkg::GAIN_UNITY && !blink_gain;
      leds_o.gain_red <= gain_r != fp_ctrl_pkg::GAIN_UNITY && !blink_gain;
      settings_o <= '{source: src_r, tbc_en: tbc_r, gain: gain_r};
    end
  end

  assign save_pulse_o = save_r;

  // ****************************************
  // register read mux
  // ****************************************
  logic [31:0] ctl_word;
  logic [31:0] sts_word;
  // fields placed by package positions, so the map lives in one place
  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[fp_ctrl_pkg::CTL_SRC_LSB +: 3] = src_r;
    ctl_word[fp_ctrl_pkg::CTL_TBC_BIT] = tbc_r;
    ctl_word[fp_ctrl_pkg::CTL_STD_BIT] = std625_r;
    sts_word = 32'h0000_0000;
    sts_word[fp_ctrl_pkg::STS_EDIT_BIT] = editing_r;
    sts_word[fp_ctrl_pkg::STS_GROUP_LSB +: 2] = group_r;
    sts_word[fp_ctrl_pkg::STS_DIRTY_BIT] = dirty_r;
    sts_word[fp_ctrl_pkg::STS_SAVE_BIT] = save_r;
    sts_word[fp_ctrl_pkg::STS_INP_BIT] = inp_det;
    sts_word[fp_ctrl_pkg::STS_REF_BIT] = ref_det;
  end

  // loaded in the wait cycle only, so the word stands while waitrequest is low
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !rd_done_r) begin
      if (avs_address_i == fp_ctrl_pkg::OFS_CONTROL) begin
        avs_readdata_o <= ctl_word;
      end else if (avs_address_i == fp_ctrl_pkg::OFS_STATUS) begin
        avs_readdata_o <= sts_word;
      end else if (avs_address_i == fp_ctrl_pkg::OFS_GAIN) begin
        avs_readdata_o <= {24'h0, gain_r};
      end else if (avs_address_i == fp_ctrl_pkg::OFS_LEDS) begin
        avs_readdata_o <= {21'h0, leds_o};
      end else begin
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

endmodule // fp_ctrl

// [verification/fp_ctrl_assertions.sv]
`timescale 1ns/10ps
module fp_ctrl_assertions (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic input_detect_i,
  input wire logic ref_detect_i,
  input wire fp_ctrl_pkg::leds_s leds_o,
  input wire fp_ctrl_pkg::settings_s settings_o,
  input wire logic save_pulse_o,
  input wire logic output_frame_start_o
);
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence src_held;
    $stable(settings_o.source)[*2];
  endsequence
  wait_low_a: assert property (avs_write_i |-> !avs_waitrequest_o) else $error("write stalled");
  read_wait_a: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read stalled twice");
  ref_led_a: assert property ($stable(ref_detect_i)[*5] |->
    leds_o.ref_green == ref_detect_i) else $error("ref led wrong");
  input_led_a: assert property ($stable({settings_o.source, input_detect_i})[*5] |->
    leds_o.input_green == (input_detect_i && settings_o.source < 3'h4)) else $error("input led");
  source_led_a: assert property (src_held ##0 (|leds_o.source_green) |->
    leds_o.source_green == 6'h1 << settings_o.source) else $error("source led wrong");
  gain_led_a: assert property ($stable(settings_o.gain)[*2] ##0
    (leds_o.gain_green || leds_o.gain_red) |-> leds_o.gain_red != leds_o.gain_green &&
    leds_o.gain_green == (settings_o.gain == fp_ctrl_pkg::GAIN_UNITY)) else $error("gain led");
  tbc_led_a: assert property ($stable(settings_o.tbc_en)[*2] |->
    !leds_o.tbc_green || settings_o.tbc_en) else $error("tbc led while off");
  save_single_a: assert property (save_pulse_o |=> (!save_pulse_o)[*8]) else $error("save twice");
  frame_gate_a: assert property ((!settings_o.tbc_en)[*5] |-> !output_frame_start_o)
    else $error("frame start while sync off");
  gain_read_a: assert property (avs_read_i && avs_waitrequest_o &&
    avs_address_i == fp_ctrl_pkg::OFS_GAIN |=> avs_readdata_o == {24'h0, settings_o.gain})
    else $error("gain read wrong");
endmodule // fp_ctrl_assertions
bind fp_ctrl fp_ctrl_assertions fp_ctrl_assertions_inst (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .input_detect_i(input_detect_i),
  .ref_detect_i(ref_detect_i), .leds_o(leds_o), .settings_o(settings_o),
  .save_pulse_o(save_pulse_o), .output_frame_start_o(output_frame_start_o));

// [verification/fp_ctrl_tb.sv]
`timescale 1ns/10ps
module fp_ctrl_tb;
  logic sys_clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, save_pulse_o;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic input_detect_i, ref_detect_i, ref_frame_start_i, output_frame_start_o;
  fp_ctrl_pkg::buttons_s buttons_i;
  fp_ctrl_pkg::leds_s leds_o;
  fp_ctrl_pkg::settings_s settings_o;
  int failures, checked, sp, fs, gg, n, e;
  fp_ctrl #(.BLINK_CYCLES(200), .FLASH_HALF(20)) fp_ctrl_inst (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .buttons_i(buttons_i),
    .input_detect_i(input_detect_i), .ref_detect_i(ref_detect_i),
    .ref_frame_start_i(ref_frame_start_i), .leds_o(leds_o), .settings_o(settings_o),
    .save_pulse_o(save_pulse_o), .output_frame_start_o(output_frame_start_o));
  fp_panel_model fp_panel_model_inst (.sys_clk_i(sys_clk_i), .buttons_o(buttons_i),
    .input_detect_o(input_detect_i), .ref_detect_o(ref_detect_i),
    .ref_frame_start_o(ref_frame_start_i));
  // ****
  // helpers
  // ****
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic results();
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] v);
    checked++;
    if (v !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, v);
    end
  endtask
  task automatic rst();
    reset_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
  endtask
  // read data taken at the edge where waitrequest is seen low; one idle edge after
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be = 4'hf);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic watch(input int c);
    sp = 0;
    fs = 0;
    gg = 0;
    repeat (c) begin
      @(posedge sys_clk_i);
      sp += (save_pulse_o === 1'b1);
      fs += (output_frame_start_o === 1'b1);
      gg += (leds_o.gain_green === 1'b1);
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    bus(1'b0, fp_ctrl_pkg::OFS_GAIN, 32'h0);
    chk("gain reg", 32'h64, q);
    bus(1'b0, fp_ctrl_pkg::OFS_CONTROL, 32'h0);
    chk("control reg", 32'h10, q);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("leds", 11'h026, leds_o);
  endtask
  task automatic t_src();
    fp_panel_model_inst.set_det(1'b1, 1'b1);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, fp_ctrl_pkg::OFS_CONTROL, 32'h10 | i);
      repeat (2) @(posedge sys_clk_i);
      e = (i > 5) ? 5 : i;
      chk("source", e, settings_o.source);
      chk("source led", 6'h1 << e, leds_o.source_green);
      chk("input led", e < 4, leds_o.input_green);
    end
    chk("ref led", 1, leds_o.ref_green);
    bus(1'b1, fp_ctrl_pkg::OFS_CONTROL, 32'h10);
  endtask
  task automatic t_bus();
    bus(1'b1, fp_ctrl_pkg::OFS_GAIN, 32'h70);
    bus(1'b1, fp_ctrl_pkg::OFS_GAIN, 32'h50, 4'he);
    bus(1'b0, fp_ctrl_pkg::OFS_GAIN, 32'h0);
    chk("gain lane", 32'h70, q);
    bus(1'b0, fp_ctrl_pkg::OFS_LEDS, 32'h0);
    chk("leds reg", 32'h03d, q);
    bus(1'b0, fp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk("status idle", 32'h60, q);
    bus(1'b1, fp_ctrl_pkg::OFS_GAIN, 32'h64);
  endtask
  task automatic t_panel();
    fp_panel_model_inst.press(3'h4);
    bus(1'b0, fp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk("group src", 3'h1, q[2:0]);
    fp_panel_model_inst.press(3'h1);
    chk("src up", 1, settings_o.source);
    fp_panel_model_inst.press(3'h2);
    chk("src down", 0, settings_o.source);
    fp_panel_model_inst.press(3'h4);
    bus(1'b0, fp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk("group tbc", 3'h3, q[2:0]);
    fp_panel_model_inst.press(3'h2);
    chk("tbc off", 0, {settings_o.tbc_en, leds_o.tbc_green});
    fp_panel_model_inst.press(3'h1);
    chk("tbc on", 1, settings_o.tbc_en);
    fp_panel_model_inst.press(3'h4);
    bus(1'b0, fp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk("group gain", 3'h5, q[2:0]);
    fp_panel_model_inst.press(3'h1);
    chk("gain up", 8'h65, settings_o.gain);
    fp_panel_model_inst.press(3'h3);
    chk("gain unity", 8'h64, settings_o.gain);
    watch(100);
    chk("blink", 1, gg > 0 && gg < 100);
    fp_panel_model_inst.press(3'h1);
    watch(150);
    chk("no early save", 0, sp);
    bus(1'b0, fp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk("pending", 32'h6d, q);
    n = 0;
    while (save_pulse_o !== 1'b1 && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("save time", 1, n > 38 && n < 56);
    watch(250);
    chk("single save", 0, sp);
    chk("gain red", 2'h1, {leds_o.gain_green, leds_o.gain_red});
  endtask
  task automatic t_power();
    fp_panel_model_inst.press(3'h1);
    watch(100);
    rst();
    watch(300);
    chk("lost save", 0, sp);
    chk("lost gain", 8'h64, settings_o.gain);
  endtask
  task automatic t_frame();
    bus(1'b1, fp_ctrl_pkg::OFS_CONTROL, 32'h30);
    bus(1'b0, fp_ctrl_pkg::OFS_CONTROL, 32'h0);
    chk("standard", 32'h30, q);
    fork
      fp_panel_model_inst.frame();
      watch(12);
    join
    chk("frame aligned", 1, fs);
    bus(1'b1, fp_ctrl_pkg::OFS_CONTROL, 32'h20);
    fork
      fp_panel_model_inst.frame();
      watch(12);
    join
    chk("frame off", 0, fs);
    chk("tbc led off", 0, leds_o.tbc_green);
    fp_panel_model_inst.press(3'h4);
    fp_panel_model_inst.press(3'h1);
    bus(1'b0, fp_ctrl_pkg::OFS_CONTROL, 32'h0);
    chk("host only", 32'h21, q);
    repeat (3) fp_panel_model_inst.press(3'h4);
    bus(1'b0, fp_ctrl_pkg::OFS_STATUS, 32'h0);
    chk("group wrap", 3'h1, q[2:0]);
  endtask
  initial begin
    reset_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    failures = 0;
    checked = 0;
    rst();
    t_reset();
    t_src();
    t_bus();
    t_panel();
    t_power();
    t_frame();
    results();
  end
  // whole run is near 1200 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    results();
  end
endmodule // fp_ctrl_tb

// [verification/fp_panel_model.sv]
`timescale 1ns/10ps
module fp_panel_model (
  input wire logic sys_clk_i,
  output fp_ctrl_pkg::buttons_s buttons_o,
  output logic input_detect_o,
  output logic ref_detect_o,
  output logic ref_frame_start_o
);
  // ****
  // panel pins and reference
  // ****
  initial begin
    buttons_o = 3'h0;
    input_detect_o = 1'b0;
    ref_detect_o = 1'b0;
    ref_frame_start_o = 1'b0;
  end
  // held long enough to pass the two-stage sync
  task automatic press(input logic [2:0] b);
    @(posedge sys_clk_i);
    buttons_o <= b;
    repeat (4) @(posedge sys_clk_i);
    buttons_o <= 3'h0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic set_det(input logic i, input logic r);
    @(posedge sys_clk_i);
    input_detect_o <= i;
    ref_detect_o <= r;
  endtask
  task automatic frame();
    @(posedge sys_clk_i);
    ref_frame_start_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ref_frame_start_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
endmodule // fp_panel_model
